// file: hdl/trap_entry_map.svh
// offsets, field positions, reset values and limits of the trap entry block
`ifndef TRAP_ENTRY_MAP_SVH
`define TRAP_ENTRY_MAP_SVH

// apb register byte offsets
`define OFS_TRAP_BASE 8'h00
`define OFS_STATE_WORD 8'h04
`define OFS_DEPTH_LEVEL 8'h08
`define OFS_LAST_TT 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_SAVED_PC 8'h18
`define OFS_SAVED_NPC 8'h1C
`define OFS_SAVED_MISC 8'h20

// processor state word fields
`define PSW_PRIV_BIT 0
`define PSW_IE_BIT 1
`define PSW_HYPER_BIT 2
`define PSW_RESET 8'h01
`define PSW_ON_TRAP 8'h01

// trap depth limits
`define MAX_PRIV_DEPTH 3'h2
`define MAX_DEPTH 3'h6
`define STACK_ENTRIES 7

// trap types and table layout
`define TT_SW_HALF 9'h100
`define TT_RESET 9'h001
`define TT_ASYNC_ERR 9'h040
`define TT_IRQ_BASE 9'h041
`define TT_CLEAN_FIRST 9'h024
`define TT_CLEAN_LAST 9'h027
`define TT_SPILL_FIRST 9'h080
`define TT_FILL_LAST 9'h0FF
`define ENTRY_SHORT 6'h08
`define ENTRY_LONG 6'h20
`define BASE_LSB 15
`define LEVEL_BIT 14
`define ENTRY_SHIFT 5

// interrupt status bits
`define IRQ_TAKEN 0
`define IRQ_TO_HYPER 1
`define IRQ_DEPTH_ERR 2
`define IRQ_BITS 3

`endif

// file: hdl/trap_entry_pkg.sv
// types shared by the trap entry block and its users
`include "trap_entry_map.svh"

package trap_entry_pkg;

  typedef enum logic [2:0] {
    MODE_USER = 3'b001,
    MODE_PRIV = 3'b010,
    MODE_HYPER = 3'b100
  } priv_mode_t;

  typedef enum logic [3:0] {
    CAT_PRECISE = 4'b0001,
    CAT_DEFERRED = 4'b0010,
    CAT_DISRUPTING = 4'b0100,
    CAT_RESET = 4'b1000
  } trap_cat_t;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] npc;
    logic [4:0] current_window_pointer;
    logic [7:0] address_space_identifier;
    logic [7:0] condition_code_flags;
  } arch_state_t;

  typedef struct packed {
    arch_state_t arch;
    logic [7:0] processor_state_word;
    logic [8:0] tt;
    priv_mode_t mode;
  } saved_entry_t;

  typedef struct packed {
    logic taken;
    logic [31:0] vector;
    logic [8:0] tt;
    trap_cat_t category;
    logic to_hyper;
    logic [5:0] handler_insns;
  } trap_out_t;

  typedef struct packed {
    logic valid;
    arch_state_t arch;
  } resume_out_t;

endpackage

// file: hdl/trap_entry_control.sv
// per-strand trap selection, state save, vectoring and return
// Functional notes
// - entries hold eight instructions; window entries 32
// - privileged vectors use trap table base register
// - handler offset from trap type and level
// - table halves: hardware traps, software traps
// - push pcs, window, asi, codes, state, type
// - level picks stack slot and vector bit
// - enter privileged mode, fetch from vector
// - check pending causes each boundary, highest wins; a boundary with ret_req checks none
// - causes: swtrap, exception, reset, error, interrupt
// - catastrophic errors use normal error path
// - exactly one of three privilege modes
// - privilege bit zero user, one privileged
// - delivery mode from type, level, mode
// - user or privileged traps go either way
// - privileged software runs at level two max
// - every trap gets one of four categories
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module trap_entry_control #(
  parameter int IRQ_LINES = 15
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pipeline boundary and state
  input wire logic insn_boundary,
  input wire trap_entry_pkg::arch_state_t cur_state,
  // trap causes
  input wire logic tcc_req,
  input wire logic [7:0] tcc_num,
  input wire logic exc_req,
  input wire logic [8:0] exc_tt,
  input wire logic reset_req,
  input wire logic async_err_req,
  input wire logic [IRQ_LINES-1:0] irq_lines,
  // return instructions
  input wire logic ret_req,
  input wire logic ret_is_done,
  // trap and resume results
  output trap_entry_pkg::trap_out_t trap_out,
  output trap_entry_pkg::resume_out_t resume_out,
  // mode, level and interrupt
  output trap_entry_pkg::priv_mode_t priv_mode,
  output logic [2:0] trap_depth_level,
  output logic privilege_bit,
  output logic irq
);
  import trap_entry_pkg::*;

  typedef struct packed {
    logic [31:0] trap_table_base;
    logic [7:0] processor_state_word;
    priv_mode_t mode;
    logic [2:0] level;
    logic [8:0] last_tt;
    logic [`IRQ_BITS-1:0] irq_status;
    logic [`IRQ_BITS-1:0] irq_mask;
    saved_entry_t [`STACK_ENTRIES-1:0] saved_state_stack;
    trap_out_t trap_o;
    resume_out_t resume_o;
    logic [31:0] rdata;
    logic slverr;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // handler length: window clean, spill and fill entries are long
  function automatic logic [5:0] entry_len(input logic [8:0] tt);
    logic is_long;
    is_long = (tt >= `TT_CLEAN_FIRST && tt <= `TT_CLEAN_LAST) ||
              (tt >= `TT_SPILL_FIRST && tt <= `TT_FILL_LAST);
    return is_long ? `ENTRY_LONG : `ENTRY_SHORT;
  endfunction

  // per-line interrupt gating by enable bit
  logic [IRQ_LINES-1:0] irq_live;
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_LINES; gi++) begin : g_irq
      assign irq_live[gi] = irq_lines[gi] &
        state_reg.processor_state_word[`PSW_IE_BIT];
    end
  endgenerate

  // lowest numbered live interrupt line
  logic irq_any;
  logic [8:0] irq_tt;
  always_comb begin
    irq_any = 1'b0;
    irq_tt = `TT_IRQ_BASE;
    for (int i = IRQ_LINES - 1; i >= 0; i--) begin
      if (irq_live[i]) begin
        irq_any = 1'b1;
        irq_tt = 9'(`TT_IRQ_BASE + 9'(i));
      end
    end
  end

  // cause selection and delivery decision
  logic pick;
  logic [8:0] pick_tt;
  trap_cat_t pick_cat;
  logic pick_hyper;
  logic [2:0] new_level;
  logic [31:0] vec;
  always_comb begin
    pick = insn_boundary & ~ret_req;
    pick_tt = 9'h000;
    pick_cat = CAT_PRECISE;
    // fixed priority: reset, error, exception, software trap, interrupt
    if (reset_req) begin
      pick_tt = `TT_RESET;
      pick_cat = CAT_RESET;
    end else if (async_err_req) begin
      pick_tt = `TT_ASYNC_ERR;
      pick_cat = CAT_DEFERRED;
    end else if (exc_req) begin
      pick_tt = {1'b0, exc_tt[7:0]};
      pick_cat = CAT_PRECISE;
    end else if (tcc_req) begin
      pick_tt = `TT_SW_HALF | {1'b0, tcc_num};
      pick_cat = CAT_PRECISE;
    end else if (irq_any) begin
      pick_tt = irq_tt;
      pick_cat = CAT_DISRUPTING;
    end else begin
      pick = 1'b0;
    end
    // at or beyond the privileged depth limit, for reset and deferred, or from hyper mode, go hyper
    pick_hyper = (state_reg.level >= `MAX_PRIV_DEPTH) ||
                 (pick_cat == CAT_RESET) || (pick_cat == CAT_DEFERRED) ||
                 (state_reg.mode == MODE_HYPER);
    new_level = (state_reg.level < `MAX_DEPTH) ?
                3'(state_reg.level + 3'h1) : `MAX_DEPTH;
    vec = {state_reg.trap_table_base[31:`BASE_LSB],
           (state_reg.level != 3'h0),
           pick_tt, 5'h00};
  end

  // apb decode
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  always_comb begin
    wr_en = psel & penable & pwrite;
    rd_setup = psel & ~penable & ~pwrite;
    unique case (paddr)
      `OFS_TRAP_BASE, `OFS_STATE_WORD, `OFS_DEPTH_LEVEL, `OFS_LAST_TT,
      `OFS_IRQ_STATUS, `OFS_IRQ_MASK, `OFS_SAVED_PC, `OFS_SAVED_NPC,
      `OFS_SAVED_MISC:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  saved_entry_t top_entry;
  assign top_entry = state_reg.saved_state_stack[state_reg.level];

  always_comb begin
    logic [`IRQ_BITS-1:0] irq_set;
    saved_entry_t push;
    irq_set = '0;
    push = '0;
    state_next = state_reg;
    state_next.trap_o.taken = 1'b0;
    state_next.resume_o.valid = 1'b0;

    // software register writes
    if (wr_en && addr_ok) begin
      unique case (paddr)
        `OFS_TRAP_BASE:
          state_next.trap_table_base = {pwdata[31:`BASE_LSB], 15'h0000};
        `OFS_STATE_WORD: begin
          state_next.processor_state_word = {5'h00, 1'b0, pwdata[1:0]};
          if (state_reg.mode != MODE_HYPER) begin
            state_next.mode = pwdata[`PSW_PRIV_BIT] ? MODE_PRIV : MODE_USER;
          end
        end
        `OFS_DEPTH_LEVEL: begin
          // privileged software cannot lift itself past its depth limit
          if (state_reg.mode != MODE_HYPER && pwdata[2:0] > `MAX_PRIV_DEPTH) begin
            state_next.level = `MAX_PRIV_DEPTH;
          end else begin
            state_next.level = (pwdata[2:0] > `MAX_DEPTH) ? `MAX_DEPTH : pwdata[2:0];
          end
        end
        `OFS_IRQ_STATUS:
          state_next.irq_status = state_reg.irq_status & ~pwdata[`IRQ_BITS-1:0];
        `OFS_IRQ_MASK:
          state_next.irq_mask = pwdata[`IRQ_BITS-1:0];
        default: ;
      endcase
    end

    if (ret_req) begin
      // restore from current level, then drop it
      // nothing is saved at level zero, so a stray return changes nothing
      if (state_reg.level != 3'h0) begin
        state_next.processor_state_word = top_entry.processor_state_word;
        state_next.mode = top_entry.mode;
        state_next.resume_o.valid = 1'b1;
        state_next.resume_o.arch = top_entry.arch;
        if (ret_is_done) begin
          state_next.resume_o.arch.pc = top_entry.arch.npc;
          state_next.resume_o.arch.npc = 32'(top_entry.arch.npc + 32'h0000_0004);
        end
        state_next.level = 3'(state_reg.level - 3'h1);
      end
    end else if (pick) begin
      push.arch = cur_state;
      push.processor_state_word = state_reg.processor_state_word;
      push.tt = pick_tt;
      push.mode = state_reg.mode;
      state_next.level = new_level;
      state_next.saved_state_stack[new_level] = push;
      state_next.processor_state_word = `PSW_ON_TRAP;
      state_next.mode = pick_hyper ? MODE_HYPER : MODE_PRIV;
      state_next.last_tt = pick_tt;
      state_next.trap_o.taken = 1'b1;
      state_next.trap_o.vector = vec;
      state_next.trap_o.tt = pick_tt;
      state_next.trap_o.category = pick_cat;
      state_next.trap_o.to_hyper = pick_hyper;
      state_next.trap_o.handler_insns = entry_len(pick_tt);
      irq_set[`IRQ_TAKEN] = 1'b1;
      irq_set[`IRQ_TO_HYPER] = pick_hyper;
      irq_set[`IRQ_DEPTH_ERR] = (state_reg.level == `MAX_DEPTH);
    end

    // software misuse: user mode above level zero
    if (state_reg.mode == MODE_USER && state_reg.level != 3'h0) begin
      irq_set[`IRQ_DEPTH_ERR] = 1'b1;
    end

    // set wins over write-one-clear
    state_next.irq_status = state_next.irq_status | irq_set;

    // read data captured in the setup cycle
    state_next.slverr = psel & ~penable & ~addr_ok;
    if (rd_setup) begin
      unique case (paddr)
        `OFS_TRAP_BASE: state_next.rdata = state_reg.trap_table_base;
        `OFS_STATE_WORD:
          state_next.rdata = {24'h000000, state_reg.processor_state_word[7:3],
                              state_reg.mode == MODE_HYPER,
                              state_reg.processor_state_word[1:0]};
        `OFS_DEPTH_LEVEL: state_next.rdata = {29'h0, state_reg.level};
        `OFS_LAST_TT: state_next.rdata = {23'h0, state_reg.last_tt};
        `OFS_IRQ_STATUS: state_next.rdata = {29'h0, state_reg.irq_status};
        `OFS_IRQ_MASK: state_next.rdata = {29'h0, state_reg.irq_mask};
        `OFS_SAVED_PC: state_next.rdata = top_entry.arch.pc;
        `OFS_SAVED_NPC: state_next.rdata = top_entry.arch.npc;
        `OFS_SAVED_MISC:
          state_next.rdata = {top_entry.tt[7:0],
                              top_entry.arch.condition_code_flags,
                              top_entry.arch.address_space_identifier,
                              top_entry.processor_state_word[2:0],
                              top_entry.arch.current_window_pointer};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.processor_state_word <= `PSW_RESET;
      state_reg.mode <= MODE_PRIV;
      state_reg.trap_o.category <= CAT_PRECISE;
      // unwritten stack slots still restore a legal mode
      for (int k = 0; k < `STACK_ENTRIES; k++) begin
        state_reg.saved_state_stack[k].mode <= MODE_PRIV;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & state_reg.slverr;
  assign trap_out = state_reg.trap_o;
  assign resume_out = state_reg.resume_o;
  assign priv_mode = state_reg.mode;
  assign trap_depth_level = state_reg.level;
  assign privilege_bit = state_reg.processor_state_word[`PSW_PRIV_BIT];
  assign irq = |(state_reg.irq_status & state_reg.irq_mask);

endmodule

`default_nettype wire

// file: sim/trap_entry_checker.sv
// assertions on the trap entry block ports
`timescale 1ns/100ps
`default_nettype none
module trap_entry_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // causes
  input wire logic insn_boundary,
  input wire logic ret_req,
  input wire logic reset_req,
  input wire logic async_err_req,
  input wire logic exc_req,
  input wire logic tcc_req,
  input wire logic [7:0] tcc_num,
  // results
  input wire trap_entry_pkg::trap_out_t trap_out,
  input wire trap_entry_pkg::resume_out_t resume_out,
  input wire trap_entry_pkg::priv_mode_t priv_mode,
  input wire logic [2:0] trap_depth_level,
  input wire logic privilege_bit
);
  import trap_entry_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_bnd; insn_boundary && !ret_req; endsequence
  sequence s_any; s_bnd ##0 (reset_req || async_err_req || exc_req || tcc_req); endsequence
  sequence s_tcc; s_bnd ##0 (tcc_req && !exc_req && !reset_req && !async_err_req); endsequence
  property p_one_mode; $onehot(priv_mode); endproperty
  a_one_mode: assert property (p_one_mode) else $error("mode not one-hot");
  property p_priv_bit;
    priv_mode != MODE_HYPER |-> privilege_bit == (priv_mode == MODE_PRIV);
  endproperty
  a_priv_bit: assert property (p_priv_bit) else $error("privilege bit wrong");
  property p_reset_take; s_bnd ##0 reset_req |=> trap_out.taken && trap_out.tt == 9'h001; endproperty
  a_reset_take: assert property (p_reset_take) else $error("reset not taken");
  property p_depth_up;
    s_any ##0 trap_depth_level < 3'h6 |=> trap_depth_level == $past(trap_depth_level) + 3'h1;
  endproperty
  a_depth_up: assert property (p_depth_up) else $error("level not raised");
  property p_vec_level; s_any |=> trap_out.vector[14] == ($past(trap_depth_level) != 3'h0); endproperty
  a_vec_level: assert property (p_vec_level) else $error("vector level bit wrong");
  property p_vec_tt; trap_out.taken |-> trap_out.vector[13:5] == trap_out.tt; endproperty
  a_vec_tt: assert property (p_vec_tt) else $error("vector offset wrong");
  property p_tcc_half; s_tcc |=> trap_out.tt == {1'b1, $past(tcc_num)}; endproperty
  a_tcc_half: assert property (p_tcc_half) else $error("software half wrong");
  property p_insns;
    trap_out.taken |-> trap_out.handler_insns ==
      ((trap_out.tt inside {[9'h024:9'h027], [9'h080:9'h0FF]}) ? 6'h20 : 6'h08);
  endproperty
  a_insns: assert property (p_insns) else $error("entry size wrong");
  property p_return;
    ret_req && trap_depth_level != 3'h0 |=>
      resume_out.valid && trap_depth_level == $past(trap_depth_level) - 3'h1;
  endproperty
  a_return: assert property (p_return) else $error("return wrong");
  property p_entry_mode;
    trap_out.taken |-> (trap_out.to_hyper ? priv_mode == MODE_HYPER : priv_mode == MODE_PRIV);
  endproperty
  a_entry_mode: assert property (p_entry_mode) else $error("entry mode wrong");
  property p_category; trap_out.taken |-> $onehot(trap_out.category); endproperty
  a_category: assert property (p_category) else $error("category not one-hot");
endmodule
bind trap_entry_control trap_entry_checker trap_entry_checker_inst (.pclk(pclk),
  .presetn(presetn), .insn_boundary(insn_boundary), .ret_req(ret_req), .reset_req(reset_req),
  .async_err_req(async_err_req), .exc_req(exc_req), .tcc_req(tcc_req), .tcc_num(tcc_num),
  .trap_out(trap_out), .resume_out(resume_out), .priv_mode(priv_mode),
  .trap_depth_level(trap_depth_level), .privilege_bit(privilege_bit));
`default_nettype wire

// file: sim/irq_source.sv
// interrupt source setting line irq_idx on irq_go and clearing line irq_idx when its trap is taken
`timescale 1ns/100ps
`default_nettype none
module irq_source #(
  parameter int N = 15
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_go,
  input wire logic [3:0] irq_idx,
  input wire trap_entry_pkg::trap_out_t trap_out,
  output logic [N-1:0] lines
);
  import trap_entry_pkg::*;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines <= '0;
    end else begin
      if (irq_go) lines[irq_idx] <= 1'b1;
      if (trap_out.taken && trap_out.tt == 9'h041 + irq_idx) lines[irq_idx] <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: sim/test_trap_entry_control.sv
// self-checking bench for the trap entry block
`timescale 1ns/100ps
`default_nettype none
module test_trap_entry_control;
  import trap_entry_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [7:0] paddr = '0, tcc_num = '0;
  logic [31:0] pwdata = '0, prdata, r, base = 32'hABCD_8000;
  logic pready, pslverr, irq, privilege_bit, insn_boundary = 0, tcc_req = 0, exc_req = 0;
  logic reset_req = 0, async_err_req = 0, ret_req = 0, ret_is_done = 0, irq_go = 0;
  logic [8:0] exc_tt = '0;
  logic [3:0] irq_idx = '0;
  logic [14:0] irq_lines;
  logic [2:0] trap_depth_level;
  logic [7:0] tts[6] = '{8'h23, 8'h24, 8'h27, 8'h7F, 8'h80, 8'hFF};
  arch_state_t cur_state = '0;
  trap_out_t trap_out;
  resume_out_t resume_out;
  priv_mode_t priv_mode, m = MODE_PRIV;
  priv_mode_t q_m[$];
  logic [31:0] q_pc[$];
  int n_mismatch = 0, compares = 0, lvl = 0;
  always #12.5 pclk = ~pclk;
  trap_entry_control #(.IRQ_LINES(15)) trap_entry_control_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .insn_boundary(insn_boundary),
    .cur_state(cur_state), .tcc_req(tcc_req), .tcc_num(tcc_num), .exc_req(exc_req),
    .exc_tt(exc_tt), .reset_req(reset_req), .async_err_req(async_err_req),
    .irq_lines(irq_lines), .ret_req(ret_req), .ret_is_done(ret_is_done), .trap_out(trap_out),
    .resume_out(resume_out), .priv_mode(priv_mode), .trap_depth_level(trap_depth_level),
    .privilege_bit(privilege_bit), .irq(irq));
  irq_source #(.N(15)) irq_source_inst (.pclk(pclk), .presetn(presetn), .irq_go(irq_go),
    .irq_idx(irq_idx), .trap_out(trap_out), .lines(irq_lines));
  task automatic close_out;
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic trap(input int kind, input logic [7:0] v);
    logic [31:0] pc;
    logic [8:0] tt;
    logic h;
    trap_cat_t c;
    pc = $urandom & 32'hFFFF_FFFC;
    c = (kind == 3) ? CAT_RESET : (kind == 2) ? CAT_DEFERRED :
      (kind == 4) ? CAT_DISRUPTING : CAT_PRECISE;
    tt = (kind == 1) ? {1'b1, v} : (kind == 2) ? 9'h040 : (kind == 3) ? 9'h001 :
      (kind == 4) ? 9'h041 + v : {1'b0, v};
    h = lvl >= 2 || kind == 2 || kind == 3 || m == MODE_HYPER;
    if (kind == 4) begin
      @(posedge pclk);
      irq_go <= 1'b1;
      irq_idx <= v[3:0];
      @(posedge pclk);
      irq_go <= 1'b0;
    end
    @(posedge pclk);
    insn_boundary <= 1'b1;
    cur_state <= '{pc, pc + 32'h4, 5'h03, 8'h80, 8'h0F};
    {exc_req, exc_tt, tcc_req, tcc_num} <= {kind == 0 || kind == 5, 1'b0, v,
      kind == 1 || kind == 5, v};
    {async_err_req, reset_req} <= {kind == 2, kind == 3};
    @(posedge pclk);
    {insn_boundary, exc_req, tcc_req, async_err_req, reset_req} <= '0;
    @(negedge pclk);
    chk("taken", 1, trap_out.taken);
    chk("tt", tt, trap_out.tt);
    chk("vector", {base[31:15], lvl != 0, tt, 5'h00}, trap_out.vector);
    chk("insns", (tt inside {[9'h024:9'h027], [9'h080:9'h0FF]}) ? 32 : 8,
      trap_out.handler_insns);
    chk("to_hyper", h, trap_out.to_hyper);
    chk("category", c, trap_out.category);
    chk("mode", h ? MODE_HYPER : MODE_PRIV, priv_mode);
    if (lvl < 6) lvl++;
    chk("level", lvl, trap_depth_level);
    q_pc.push_back(pc);
    q_m.push_back(m);
    m = h ? MODE_HYPER : MODE_PRIV;
  endtask
  task automatic ret(input logic done);
    logic [31:0] pc;
    pc = q_pc.pop_back();
    @(posedge pclk);
    {ret_req, ret_is_done} <= {1'b1, done};
    @(posedge pclk);
    ret_req <= 1'b0;
    @(negedge pclk);
    chk("resume", 1, resume_out.valid);
    chk("pc", done ? pc + 4 : pc, resume_out.arch.pc);
    chk("npc", done ? pc + 8 : pc + 4, resume_out.arch.npc);
    chk("misc", {5'h03, 8'h80, 8'h0F}, resume_out.arch[20:0]);
    lvl--;
    m = q_m.pop_back();
    chk("level", lvl, trap_depth_level);
    chk("mode", m, priv_mode);
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    close_out;
  end
  initial begin
    void'($urandom(36472));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("mode", MODE_PRIV, priv_mode);
    chk("priv", 1, privilege_bit);
    chk("level", 0, trap_depth_level);
    apb(1, 8'h00, base);
    apb(0, 8'h00, 0);
    chk("base", base, r);
    apb(0, 8'h24, 0);
    chk("unmapped", 1, e);
    apb(1, 8'h08, 32'h7);
    apb(0, 8'h08, 0);
    chk("clamp", 2, r);
    chk("slverr", 0, e);
    apb(1, 8'h08, 32'h0);
    apb(1, 8'h14, 32'h7);
    apb(1, 8'h04, 32'h0);
    @(negedge pclk);
    chk("user", MODE_USER, priv_mode);
    chk("priv", 0, privilege_bit);
    m = MODE_USER;
    foreach (tts[i]) begin
      trap(0, tts[i]);
      ret(i[0]);
    end
    apb(0, 8'h10, 0);
    chk("status", 1, r);
    chk("irq", 1, irq);
    apb(1, 8'h10, 32'h7);
    @(negedge pclk);
    chk("irq", 0, irq);
    apb(1, 8'h04, 32'h3);
    m = MODE_PRIV;
    trap(4, 8'h03);
    trap(5, 8'h08 + 8'($urandom % 16));
    trap(1, 8'($urandom % 16));
    trap(2, 8'h00);
    trap(3, 8'h00);
    apb(0, 8'h0C, 0);
    chk("last tt", 32'h0000_0001, r);
    apb(0, 8'h18, 0);
    chk("saved pc", q_pc[$], r);
    apb(0, 8'h20, 0);
    chk("saved misc", {8'h01, 8'h0F, 8'h80, 3'b001, 5'h03}, r);
    for (int i = 0; i < 5; i++) ret(i[0]);
    apb(0, 8'h10, 0);
    chk("status", 3, r);
    chk("irq", 1, irq);
    close_out;
  end
endmodule
`default_nettype wire
